// ===== hdl/clcfg_pkg.sv
// Package for the closed-loop configuration register bank: offsets, field layout, tables, carriers.
// Assumes a single 200 MHz clock domain and an APB master with 32-bit data.
package clcfg_pkg;

  localparam logic [31:0] CLCFG_CONFIG_OFFSET = 32'h0000_0044;
  localparam logic [31:0] CLCFG_CONFIG_RESET  = 32'h0000_0000;
  // Writable bits: 29-13, 12-8 and 3; everything else reads zero
  localparam logic [31:0] CLCFG_CONFIG_WMASK  = 32'h3FFF_FF08;

  localparam int CLCFG_MODE_LSB    = 28;
  localparam int CLCFG_FAST_BIT    = 27;
  localparam int CLCFG_CAP_LSB     = 22;
  localparam int CLCFG_STOP_LSB    = 20;
  localparam int CLCFG_OVERMOD_BIT = 19;
  localparam int CLCFG_ACCEL_LSB   = 14;
  localparam int CLCFG_DSRC_BIT    = 13;
  localparam int CLCFG_DECEL_LSB   = 8;
  localparam int CLCFG_AVS_BIT     = 3;

  localparam logic [4:0] CLCFG_RATE_FAST_KHZ = 5'h10;
  localparam logic [4:0] CLCFG_RATE_SLOW_KHZ = 5'h08;
  localparam logic [4:0] CLCFG_CAP_TOP_CODE  = 5'h1D;
  localparam logic [4:0] CLCFG_NO_LIMIT_CODE = 5'h1F;

  typedef enum logic [1:0] {
    CLCFG_MODE_SPEED   = 2'b00,
    CLCFG_MODE_POWER   = 2'b01,
    CLCFG_MODE_TORQUE  = 2'b10,
    CLCFG_MODE_VOLTAGE = 2'b11
  } clcfg_mode_t;

  typedef enum logic [1:0] {
    CLCFG_STOP_HIZ   = 2'b00,
    CLCFG_STOP_SPIN  = 2'b01,
    CLCFG_STOP_BRAKE = 2'b10,
    CLCFG_STOP_RSVD  = 2'b11
  } clcfg_stop_t;

  // Register image, bit 31 first
  typedef struct packed {
    logic [1:0]  reserved_hi;
    clcfg_mode_t mode;
    logic        fast_sampling_select;
    logic [4:0]  current_cap_code;
    clcfg_stop_t stop_method_select;
    logic        overmod_enable;
    logic [4:0]  accel_rate_code;
    logic        decel_source_select;
    logic [4:0]  decel_rate_code;
    logic [3:0]  unused_mid;
    logic        anti_voltage_surge;
    logic [2:0]  unused_lo;
  } clcfg_reg_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } clcfg_apb_req_t;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } clcfg_apb_rsp_t;

  // Decoded controls; current limit in tenths of a percent of base current
  typedef struct packed {
    logic       speed_mode;
    logic       power_mode;
    logic       torque_mode;
    logic       voltage_mode;
    logic [4:0] max_sample_khz;
    logic       current_limit_active;
    logic [9:0] current_limit_tenths;
    logic       stop_hiz;
    logic       stop_spin_down;
    logic       stop_brake;
    logic       overmod_enable;
    logic       decel_from_field;
    logic       decel_by_avs;
  } clcfg_ctrl_t;

  // Current cap per code, tenths of a percent
  localparam logic [9:0] CLCFG_CAP_TABLE [0:29] = '{
    10'd75,  10'd80,  10'd85,  10'd90,  10'd95,  10'd100, 10'd110, 10'd120,
    10'd130, 10'd140, 10'd150, 10'd160, 10'd170, 10'd180, 10'd200, 10'd225,
    10'd250, 10'd275, 10'd300, 10'd350, 10'd400, 10'd450, 10'd500, 10'd550,
    10'd600, 10'd700, 10'd750, 10'd800, 10'd850, 10'd900
  };

  // Speed slope per code in units of 0.5 Hz/s; the last code means no limit
  localparam logic [17:0] CLCFG_RATE_TABLE [0:31] = '{
    18'd1,     18'd2,     18'd5,     18'd10,    18'd15,    18'd20,    18'd40,    18'd80,
    18'd120,   18'd160,   18'd200,   18'd400,   18'd600,   18'd800,   18'd1000,  18'd1200,
    18'd1400,  18'd1600,  18'd1800,  18'd2000,  18'd4000,  18'd8000,  18'd12000, 18'd16000,
    18'd20000, 18'd40000, 18'd60000, 18'd80000, 18'd100000, 18'd120000, 18'd140000, 18'd0
  };

endpackage : clcfg_pkg

// ===== hdl/clcfg_rate_lut.sv
// Rate lookup: turns a five-bit slope code into a registered rate.
// Assumes the code is stable from the configuration register; output lags it by one clock.
`timescale 1ns/10ps
`default_nettype none

module clcfg_rate_lut
  import clcfg_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        reset_n_i,
  input  wire logic [4:0]  code_i,
  output logic      [17:0] rate_o,
  output logic             unlimited_o
);

  typedef struct packed {
    logic [17:0] rate;
    logic        unlimited;
  } clcfg_lut_state_t;

  clcfg_lut_state_t state_ff;
  clcfg_lut_state_t nxt_state;

  always_comb begin
    nxt_state           = state_ff;
    nxt_state.rate      = CLCFG_RATE_TABLE[code_i];
    nxt_state.unlimited = (code_i == CLCFG_NO_LIMIT_CODE);
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rate_o      = state_ff.rate;
  assign unlimited_o = state_ff.unlimited;

endmodule : clcfg_rate_lut

`default_nettype wire

// ===== hdl/clcfg_top.sv
// Closed-loop motor configuration register with APB access and decoded control outputs.
// Assumes one clock, APB master with 32-bit data; decoded outputs follow a write by one clock.
//
// How it works
// - Config register at 44h, resets to zero, bits 31-30 read zero.
// - Mode field 29-28: speed, power, torque, voltage.
// - Bit 27 clear allows 16 kHz sampling, set caps at 8 kHz.
// - Current cap 26-22 in percent of base, used only in torque and speed.
// - Stop field 21-20: high impedance, spin down, brake, reserved.
// - Bit 19 permits overmodulation, otherwise linear modulation only.
// - Acceleration slope code 18-14 from 0.5 Hz/s, top code means no limit.
// - Bit 13 picks deceleration from its own field or from acceleration.
// - Own deceleration field feeds decel_rate_o whenever bit 13 is clear; decel_from_field also needs surge guard off.
`timescale 1ns/10ps
`default_nettype none

module clcfg_top
  import clcfg_pkg::*;
(
  input  wire logic            clock_i,
  input  wire logic            reset_n_i,
  input  wire clcfg_apb_req_t  apb_req_i,
  output clcfg_apb_rsp_t       apb_rsp_o,
  output clcfg_ctrl_t          ctrl_o,
  output logic          [17:0] accel_rate_o,
  output logic                 accel_unlimited_o,
  output logic          [17:0] decel_rate_o,
  output logic                 decel_unlimited_o
);

  typedef struct packed {
    clcfg_apb_rsp_t rsp;
    clcfg_reg_t     cfg;
    clcfg_ctrl_t    ctrl;
  } clcfg_state_t;

  clcfg_state_t state_ff;
  clcfg_state_t nxt_state;

  logic       hit;
  logic       setup_phase;
  logic       access_done;
  logic [4:0] decel_code;

  assign hit         = (apb_req_i.paddr == CLCFG_CONFIG_OFFSET);
  assign setup_phase = apb_req_i.psel && !apb_req_i.penable;
  assign access_done = apb_req_i.psel && apb_req_i.penable && state_ff.rsp.pready;

  // Deceleration follows the acceleration code when bit 13 is set
  assign decel_code = state_ff.cfg.decel_source_select ? state_ff.cfg.accel_rate_code
                                                       : state_ff.cfg.decel_rate_code;

  always_comb begin
    nxt_state = state_ff;

    // Answer prepared in the setup cycle, so every access has zero wait states
    nxt_state.rsp.pready  = setup_phase;
    nxt_state.rsp.pslverr = setup_phase && !hit;
    nxt_state.rsp.prdata  = '0;
    if (setup_phase && hit && !apb_req_i.pwrite) begin
      nxt_state.rsp.prdata = state_ff.cfg & CLCFG_CONFIG_WMASK;
    end
    if (access_done) begin
      nxt_state.rsp.pready  = 1'b0;
      nxt_state.rsp.pslverr = 1'b0;
    end

    // Unmapped writes are dropped; non-writable bits never hold a one
    if (access_done && apb_req_i.pwrite && hit) begin
      nxt_state.cfg = apb_req_i.pwdata & CLCFG_CONFIG_WMASK;
    end

    nxt_state.ctrl.speed_mode   = (state_ff.cfg.mode == CLCFG_MODE_SPEED);
    nxt_state.ctrl.power_mode   = (state_ff.cfg.mode == CLCFG_MODE_POWER);
    nxt_state.ctrl.torque_mode  = (state_ff.cfg.mode == CLCFG_MODE_TORQUE);
    nxt_state.ctrl.voltage_mode = (state_ff.cfg.mode == CLCFG_MODE_VOLTAGE);

    nxt_state.ctrl.max_sample_khz = state_ff.cfg.fast_sampling_select ? CLCFG_RATE_SLOW_KHZ
                                                                      : CLCFG_RATE_FAST_KHZ;

    // Cap is meaningless in power and voltage modes, so it is flagged inactive there
    nxt_state.ctrl.current_limit_active = (state_ff.cfg.mode == CLCFG_MODE_SPEED) ||
                                          (state_ff.cfg.mode == CLCFG_MODE_TORQUE);
    if (state_ff.cfg.current_cap_code > CLCFG_CAP_TOP_CODE) begin
      nxt_state.ctrl.current_limit_tenths = CLCFG_CAP_TABLE[CLCFG_CAP_TOP_CODE];
    end else begin
      nxt_state.ctrl.current_limit_tenths = CLCFG_CAP_TABLE[state_ff.cfg.current_cap_code];
    end

    // Reserved stop code falls back to high impedance, the safest output state
    nxt_state.ctrl.stop_hiz       = 1'b0;
    nxt_state.ctrl.stop_spin_down = 1'b0;
    nxt_state.ctrl.stop_brake     = 1'b0;
    case (state_ff.cfg.stop_method_select)
      CLCFG_STOP_SPIN: begin
        nxt_state.ctrl.stop_spin_down = 1'b1;
      end
      CLCFG_STOP_BRAKE: begin
        nxt_state.ctrl.stop_brake = 1'b1;
      end
      default: begin
        nxt_state.ctrl.stop_hiz = 1'b1;
      end
    endcase

    nxt_state.ctrl.overmod_enable = state_ff.cfg.overmod_enable;

    nxt_state.ctrl.decel_from_field = !state_ff.cfg.decel_source_select &&
                                      !state_ff.cfg.anti_voltage_surge;
    nxt_state.ctrl.decel_by_avs     = !state_ff.cfg.decel_source_select &&
                                      state_ff.cfg.anti_voltage_surge;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff     <= '0;
      state_ff.cfg <= CLCFG_CONFIG_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  clcfg_rate_lut u_accel_lut (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .code_i      (state_ff.cfg.accel_rate_code),
    .rate_o      (accel_rate_o),
    .unlimited_o (accel_unlimited_o)
  );

  clcfg_rate_lut u_decel_lut (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .code_i      (decel_code),
    .rate_o      (decel_rate_o),
    .unlimited_o (decel_unlimited_o)
  );

  assign apb_rsp_o = state_ff.rsp;
  assign ctrl_o    = state_ff.ctrl;

endmodule : clcfg_top

`default_nettype wire

// ===== tb/clcfg_checker.sv
// Assertions on the closed-loop configuration register ports.
// Sees only the top module's ports; bound into clcfg_top at the foot.
`timescale 1ns/10ps
`default_nettype none
module clcfg_checker
  import clcfg_pkg::*;
(
  input  wire logic           clock_i,
  input  wire logic           reset_n_i,
  input  wire clcfg_apb_req_t apb_req_i,
  input  wire clcfg_apb_rsp_t apb_rsp_o,
  input  wire clcfg_ctrl_t    ctrl_o,
  input  wire logic    [17:0] accel_rate_o,
  input  wire logic           accel_unlimited_o,
  input  wire logic    [17:0] decel_rate_o,
  input  wire logic           decel_unlimited_o
);
  logic [31:0] d1_ff;
  logic [31:0] d2_ff;
  logic        wr;
  // Write word two edges back lines up with the decoded outputs
  assign wr = apb_req_i.psel & apb_req_i.penable & apb_rsp_o.pready & apb_req_i.pwrite
              & (apb_req_i.paddr == 32'h0000_0044);
  always_ff @(posedge clock_i) begin
    d1_ff <= apb_req_i.pwdata;
    d2_ff <= d1_ff;
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  ready_timing_a: assert property (apb_req_i.psel && !apb_req_i.penable |=> apb_rsp_o.pready)
    else $error("pready not in access cycle");
  slave_err_a: assert property (apb_rsp_o.pready |-> apb_rsp_o.pslverr == (apb_req_i.paddr != 32'h0000_0044))
    else $error("pslverr wrong for address");
  reserved_zero_a: assert property ((apb_rsp_o.prdata & ~CLCFG_CONFIG_WMASK) == 32'h0000_0000)
    else $error("reserved bits not zero");
  mode_decode_a: assert property (wr |-> ##2 {ctrl_o.speed_mode, ctrl_o.power_mode, ctrl_o.torque_mode,
    ctrl_o.voltage_mode} == (4'h8 >> d2_ff[29:28])) else $error("mode decode wrong");
  sample_rate_a: assert property (wr |-> ##2 ctrl_o.max_sample_khz == (d2_ff[27] ? 5'h08 : 5'h10))
    else $error("sample rate wrong");
  cap_active_a: assert property (wr |-> ##2 ctrl_o.current_limit_active == !d2_ff[28])
    else $error("cap enable wrong");
  stop_decode_a: assert property (wr |-> ##2 {ctrl_o.stop_hiz, ctrl_o.stop_spin_down, ctrl_o.stop_brake}
    == ((d2_ff[21:20] == 2'h3) ? 3'h4 : (3'h4 >> d2_ff[21:20]))) else $error("stop decode wrong");
  cap_clamp_a: assert property ((wr && (apb_req_i.pwdata[26:22] > 5'h1D)) |-> ##2
    ctrl_o.current_limit_tenths == 10'd900) else $error("cap clamp wrong");
  overmod_a: assert property (wr |-> ##2 ctrl_o.overmod_enable == d2_ff[19])
    else $error("overmod wrong");
  accel_open_a: assert property (wr |-> ##2 accel_unlimited_o == (d2_ff[18:14] == 5'h1F))
    else $error("accel limit flag wrong");
  accel_rate_a: assert property (wr |-> ##2 (accel_rate_o == 18'h0) == (d2_ff[18:14] == 5'h1F))
    else $error("accel rate wrong");
  decel_source_a: assert property (wr |-> ##2 decel_unlimited_o
    == ((d2_ff[13] ? d2_ff[18:14] : d2_ff[12:8]) == 5'h1F)) else $error("decel source wrong");
  decel_rate_a: assert property (wr |-> ##2 (decel_rate_o == 18'h0)
    == ((d2_ff[13] ? d2_ff[18:14] : d2_ff[12:8]) == 5'h1F)) else $error("decel rate wrong");
  decel_field_a: assert property (wr |-> ##2 ctrl_o.decel_from_field == (!d2_ff[13] && !d2_ff[3]))
    else $error("decel field use wrong");
endmodule : clcfg_checker
bind clcfg_top clcfg_checker chk (.clock_i(clock_i), .reset_n_i(reset_n_i), .apb_req_i(apb_req_i),
  .apb_rsp_o(apb_rsp_o), .ctrl_o(ctrl_o), .accel_rate_o(accel_rate_o), .accel_unlimited_o(accel_unlimited_o),
  .decel_rate_o(decel_rate_o), .decel_unlimited_o(decel_unlimited_o));
`default_nettype wire

// ===== tb/clcfg_top_tb.sv
// Self-checking bench for clcfg_top over APB.
// Assumes decoded outputs settle one edge after the write edge; every transfer waits on pready.
`timescale 1ns/10ps
`default_nettype none
module clcfg_top_tb
  import clcfg_pkg::*;
;
  logic           clock_i;
  logic           reset_n_i;
  clcfg_apb_req_t req;
  clcfg_apb_rsp_t rsp;
  clcfg_ctrl_t    ctl;
  logic    [17:0] acc;
  logic           acc_u;
  logic    [17:0] dec;
  logic           dec_u;
  logic    [31:0] rd;
  logic           err;
  int             num_errors = 0;
  int             n_checks = 0;
  `define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
  clcfg_top dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .apb_req_i(req), .apb_rsp_o(rsp), .ctrl_o(ctl),
    .accel_rate_o(acc), .accel_unlimited_o(acc_u), .decel_rate_o(dec), .decel_unlimited_o(dec_u));
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock_i);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock_i);
    req.penable <= 1'b1;
    // Answer taken at the edge that sees pready high; only the watchdog ends a stuck wait
    do begin
      @(posedge clock_i);
    end while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask : apb
  task automatic wr_settle(input logic [31:0] d);
    apb(1'b1, 32'h0000_0044, d);
    repeat (2) @(posedge clock_i);
    @(negedge clock_i);
  endtask : wr_settle
  task automatic t_reset_and_map();
    // Decode of the reset word appears at the first rising edge after release
    repeat (2) @(negedge clock_i);
    `CHK("speed", 1'b1, ctl.speed_mode)
    `CHK("cap", 10'd75, ctl.current_limit_tenths)
    `CHK("khz", 5'h10, ctl.max_sample_khz)
    apb(1'b0, 32'h0000_0044, 32'h0);
    `CHK("rst", 32'h0, rd)
    wr_settle(32'hFFFF_FFFF);
    apb(1'b0, 32'h0000_0044, 32'h0);
    `CHK("mask", 32'h3FFF_FF08, rd)
    `CHK("capmax", 10'd900, ctl.current_limit_tenths)
    `CHK("accun", 19'h40000, {acc_u, acc})
    apb(1'b1, 32'h0000_0048, 32'h0);
    `CHK("werr", 1'b1, err)
    apb(1'b0, 32'h0000_0048, 32'h0);
    `CHK("rerr", 33'h1_0000_0000, {err, rd})
    apb(1'b0, 32'h0000_0044, 32'h0);
    `CHK("kept", 32'h3FFF_FF08, rd)
  endtask : t_reset_and_map
  task automatic t_modes();
    for (int m = 0; m < 16; m++) begin
      wr_settle({2'h0, m[3:2], m[0], 5'h00, m[1:0], m[1], 19'h0});
      `CHK("capon", !m[2], ctl.current_limit_active)
      `CHK("khz", m[0] ? 5'h08 : 5'h10, ctl.max_sample_khz)
      `CHK("ovm", m[1], ctl.overmod_enable)
      `CHK("mode", 4'h8 >> m[3:2], {ctl.speed_mode, ctl.power_mode, ctl.torque_mode, ctl.voltage_mode})
      `CHK("stop", (m[1:0] == 2'h3) ? 3'h4 : 3'h4 >> m[1:0], {ctl.stop_hiz, ctl.stop_spin_down, ctl.stop_brake})
    end
  endtask : t_modes
  task automatic t_rates();
    logic [4:0]  c [5] = '{5'h00, 5'h02, 5'h0E, 5'h1D, 5'h1E};
    logic [9:0]  cap [5] = '{10'd75, 10'd85, 10'd200, 10'd900, 10'd900};
    logic [17:0] r [5] = '{18'd1, 18'd5, 18'd1000, 18'd120000, 18'd140000};
    for (int i = 0; i < 5; i++) begin
      wr_settle({5'h00, c[i], 3'h0, c[4 - i], 1'b0, c[i], 8'h00});
      `CHK("cap", cap[i], ctl.current_limit_tenths)
      `CHK("acc", r[4 - i], acc)
      `CHK("dec", r[i], dec)
    end
    wr_settle(32'h0007_E008);
    `CHK("dsrc", 19'h40000, {dec_u, dec})
    wr_settle(32'h0007_C008);
    `CHK("avs", 2'b01, {ctl.decel_from_field, ctl.decel_by_avs})
  endtask : t_rates
  task automatic give_verdict();
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  initial begin
    reset_n_i = 1'b0;
    req = '0;
    repeat (4) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_reset_and_map();
    t_modes();
    t_rates();
    give_verdict();
  end
  initial begin
    #20000;
    num_errors++;
    give_verdict();
  end
endmodule : clcfg_top_tb
`default_nettype wire
